// ===== hdl/fbc_params.svh
// Constants for the flash command sequencer: command codes, unlock addresses and timing
`ifndef FBC_PARAMS_SVH
`define FBC_PARAMS_SVH
// ==============================
// Widths and address fields
`define FBC_ADDR_W 19
`define FBC_DATA_W 16
`define FBC_KEEP_LSB 12
`define FBC_UNLK1_WORD 12'h555
`define FBC_UNLK2_WORD 12'h2AA
`define FBC_UNLK1_BYTE 12'hAAA
`define FBC_UNLK2_BYTE 12'h555
`define FBC_OFS_MFR 8'h00
`define FBC_OFS_DEV_WORD 8'h01
`define FBC_OFS_DEV_BYTE 8'h02
`define FBC_OFS_PROT_WORD 8'h02
`define FBC_OFS_PROT_BYTE 8'h04
// ==============================
// Command data codes
`define FBC_D_RESET 8'hF0
`define FBC_D_UNLK1 8'hAA
`define FBC_D_UNLK2 8'h55
`define FBC_D_PROGRAM 8'hA0
`define FBC_D_BYPASS 8'h20
`define FBC_D_AUTOSEL 8'h90
`define FBC_D_BYP_EXIT 8'h00
`define FBC_D_ERASE_SETUP 8'h80
`define FBC_D_CHIP_ERASE 8'h10
`define FBC_D_SECT_ERASE 8'h30
`define FBC_D_SUSPEND 8'hB0
`define FBC_D_RESUME 8'h30
// ==============================
// Timing
`define FBC_CLK_PERIOD_NS 4
`define FBC_WE_LOW_NS 30
`define FBC_WE_LOW_CYC ((`FBC_WE_LOW_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS)
`define FBC_WE_HIGH_NS 20
`define FBC_WE_HIGH_CYC ((`FBC_WE_HIGH_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS)
`define FBC_READ_ACC_NS 70
`define FBC_READ_ACC_CYC ((`FBC_READ_ACC_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS)
`define FBC_SYNC_CYC 2
`define FBC_ERASE_WINDOW_US 50
`define FBC_ERASE_WINDOW_CYC ((`FBC_ERASE_WINDOW_US * 1000) / `FBC_CLK_PERIOD_NS)
`endif

// ===== hdl/fbc_pkg.sv
// Types shared by the flash command sequencer and its bus cycle engine
package fbc_pkg;
  typedef enum logic [3:0] {
    OP_READ, OP_RESET, OP_ID_MFR, OP_ID_DEV, OP_PROT_QUERY, OP_PROGRAM, OP_BYP_ENTER,
    OP_BYP_PROGRAM, OP_BYP_EXIT, OP_CHIP_ERASE, OP_SECT_ERASE, OP_SECT_ADD, OP_SUSPEND, OP_RESUME
  } fbc_op_t;
  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} fbc_seq_state_t;
  typedef enum logic [2:0] {P_IDLE, P_SETUP, P_STROBE, P_HOLD, P_DONE} fbc_phy_state_t;
  typedef struct packed {
    logic [18:0] addr;
    logic [15:0] data;
    logic rd;
    logic last;
  } fbc_step_t;
endpackage : fbc_pkg

// ===== hdl/fbc_cyc_if.sv
// One bus cycle request between the sequencer and the bus cycle engine
interface fbc_cyc_if;
  logic req;
  logic wr;
  logic [18:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport phy (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : fbc_cyc_if

// ===== hdl/fbc_bus_cycle.sv
// Bus cycle engine: turns one request into a timed chip-enable/write-enable/output-enable cycle
`include "fbc_params.svh"
module fbc_bus_cycle (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Request from the sequencer
  fbc_cyc_if.phy cyc,
  // Flash pins
  output logic [18:0] flash_addr_out,
  output logic flash_ce_n_out,
  output logic flash_we_n_out,
  output logic flash_oe_n_out,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe_n_out,
  input wire logic [15:0] flash_dq_in
);
  localparam int WE_LOW_MIN = `FBC_WE_LOW_CYC;
  fbc_pkg::fbc_phy_state_t st_q, st_d;
  logic [5:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic [18:0] addr_q, addr_d;
  logic [15:0] wdat_q, wdat_d, rdat_q, rdat_d;
  logic ce_n_q, ce_n_d, we_n_q, we_n_d, oe_n_q, oe_n_d, doe_n_q, doe_n_d;
  logic [15:0] dq_s1_q, dq_s2_q, dq_s3_q;
  logic [5:0] low_len_q;

  // ==============================
  // Cycle sequencing
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    rdat_d = rdat_q;
    ce_n_d = ce_n_q;
    we_n_d = we_n_q;
    oe_n_d = oe_n_q;
    doe_n_d = doe_n_q;
    case (st_q)
      fbc_pkg::P_IDLE: if (cyc.req) begin
        wr_d = cyc.wr;
        addr_d = cyc.addr;
        wdat_d = cyc.wdata;
        ce_n_d = 1'b0;
        doe_n_d = !cyc.wr;
        st_d = fbc_pkg::P_SETUP;
      end
      fbc_pkg::P_SETUP: begin
        // Address is settled a cycle before the later falling strobe, see RQ3
        we_n_d = !wr_q;
        oe_n_d = wr_q;
        cnt_d = wr_q ? 6'(`FBC_WE_LOW_CYC - 1) : 6'(`FBC_READ_ACC_CYC + `FBC_SYNC_CYC - 1);
        st_d = fbc_pkg::P_STROBE;
      end
      fbc_pkg::P_STROBE: begin
        if (cnt_q != 6'h00) begin
          cnt_d = cnt_q - 6'h01;
        end else if (wr_q || dq_s2_q == dq_s3_q) begin
          rdat_d = dq_s3_q;
          we_n_d = 1'b1;
          oe_n_d = 1'b1;
          cnt_d = 6'(`FBC_WE_HIGH_CYC - 1);
          st_d = fbc_pkg::P_HOLD;
        end
      end
      fbc_pkg::P_HOLD: begin
        // Write-enable rises first, so data is still driven at the earlier rising edge, see RQ4
        if (cnt_q != 6'h00) begin
          cnt_d = cnt_q - 6'h01;
        end else begin
          ce_n_d = 1'b1;
          doe_n_d = 1'b1;
          st_d = fbc_pkg::P_DONE;
        end
      end
      fbc_pkg::P_DONE: st_d = fbc_pkg::P_IDLE;
      default: st_d = fbc_pkg::P_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= fbc_pkg::P_IDLE;
      cnt_q <= 6'h00;
      wr_q <= 1'b0;
      addr_q <= 19'h00000;
      wdat_q <= 16'h0000;
      rdat_q <= 16'h0000;
      ce_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      doe_n_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      ce_n_q <= ce_n_d;
      we_n_q <= we_n_d;
      oe_n_q <= oe_n_d;
      doe_n_q <= doe_n_d;
    end
  end

  // ==============================
  // Read data synchroniser; a word counts once stages two and three agree
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
      dq_s3_q <= 16'h0000;
    end else begin
      dq_s1_q <= flash_dq_in;
      dq_s2_q <= dq_s1_q;
      dq_s3_q <= dq_s2_q;
    end
  end

  assign cyc.done = (st_q == fbc_pkg::P_DONE);
  assign cyc.rdata = rdat_q;
  assign flash_addr_out = addr_q;
  assign flash_ce_n_out = ce_n_q;
  assign flash_we_n_out = we_n_q;
  assign flash_oe_n_out = oe_n_q;
  assign flash_dq_out = wdat_q;
  assign flash_dq_oe_n_out = doe_n_q;

  // ==============================
  // Checks
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      low_len_q <= 6'h00;
    end else begin
      low_len_q <= we_n_q ? 6'h00 : low_len_q + 6'h01;
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  we_pulse_width_a: assert property ($rose(we_n_q) |-> low_len_q >= 6'(WE_LOW_MIN)) // see RQ3
    else $error("write strobe shorter than minimum");
  addr_stable_a: assert property (!ce_n_q && $past(!ce_n_q) |-> $stable(addr_q)) // see RQ3
    else $error("address moved inside a cycle");
  data_hold_a: assert property ($rose(we_n_q) |-> !doe_n_q && $stable(wdat_q) && !ce_n_q) // see RQ4
    else $error("write data not held past strobe rise");
  strobe_excl_a: assert property (!we_n_q |-> oe_n_q && !doe_n_q) // see RQ6
    else $error("write and read strobes overlap or data not driven");
endmodule : fbc_bus_cycle

// ===== hdl/fbc_host.sv
// Host-side command sequencer that drives a two-bank parallel flash through its pins
`include "fbc_params.svh"
// Functional notes
// RQ1: Reset write F0 returns bank to reading.
// RQ2: Sequences start with AA then 55 unlocks.
// RQ3: Address latched at later falling strobe edge.
// RQ4: Data latched at earlier rising strobe edge.
// RQ5: Sector from A18-A12, bank from A18-A16.
// RQ6: All sequence cycles are writes except reads.
// RQ7: Upper data byte ignored in command cycles.
// RQ8: Upper address ignored unless bank needed.
// RQ9: Array reads need no command writes.
// RQ10: Autoselect: 90 at bank address, then read.
// RQ11: Protect query returns 00 or 01.
// RQ12: Bypass entry 20; then two-write program works.
// RQ13: Bypass exit: 90 to bank, then 00.
// RQ14: Chip erase: six writes ending 10.
// RQ15: Sector erase: sixth write 30 at sector.
// RQ16: Suspend B0 only during sector erase.
// RQ17: Suspended bank allows reads, program, autoselect.
// RQ18: Resume 30 only while suspended.
// RQ19: Busy bank reports status bits and ready.
// RQ20: Bypass mode accepts only bypass program, reset.
// RQ21: 50 us window for extra erase sectors.
// RQ22: Running erase ignores commands but suspend.
// RQ23: Mismatching write aborts the sequence.
module fbc_host #(
  parameter int ERASE_WINDOW_CYC = `FBC_ERASE_WINDOW_CYC
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Command port
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire fbc_pkg::fbc_op_t cmd_op_in,
  input wire logic [18:0] cmd_addr_in,
  input wire logic [15:0] cmd_data_in,
  input wire logic byte_mode_in,
  // Response
  output logic rsp_valid_out,
  output logic rsp_refused_out,
  output logic [15:0] rsp_data_out,
  // Tracked device mode
  output logic bypass_out,
  output logic suspended_out,
  output logic erasing_out,
  output logic erase_window_out,
  output logic busy_out,
  // Flash pins
  output logic [18:0] flash_addr_out,
  output logic flash_ce_n_out,
  output logic flash_we_n_out,
  output logic flash_oe_n_out,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe_n_out,
  input wire logic [15:0] flash_dq_in,
  input wire logic flash_ready_busy_n_in
);
  localparam int WW = $clog2(ERASE_WINDOW_CYC + 1);

  fbc_cyc_if cyc ();
  fbc_pkg::fbc_seq_state_t st_q, st_d;
  fbc_pkg::fbc_op_t op_q, op_d;
  fbc_pkg::fbc_step_t stp;
  logic [18:0] addr_q, addr_d;
  logic [15:0] data_q, data_d, rdat_q, rdat_d;
  logic bm_q, bm_d;
  logic [2:0] step_q, step_d;
  logic rv_q, rv_d, rr_q, rr_d;
  logic byp_q, byp_d, susp_q, susp_d, erase_q, erase_d, chip_q, chip_d, seen_q, seen_d;
  logic [WW-1:0] win_q, win_d;
  logic rb_s1_q, rb_s2_q, rb_s3_q, busy_q, busy_d;

  // ==============================
  // Sequence tables
  function automatic logic [18:0] mrg(input logic [18:0] a, input logic [11:0] lo);
    // Bank and sector bits ride along; the device ignores them where no bank is needed, see RQ8 RQ5
    mrg = {a[18:`FBC_KEEP_LSB], lo};
  endfunction : mrg

  function automatic fbc_pkg::fbc_step_t step_fn(input fbc_pkg::fbc_op_t op, input logic [2:0] s,
                                                 input logic bm, input logic [18:0] a, input logic [15:0] d);
    logic [11:0] u1;
    logic [11:0] u2;
    logic [7:0] ofs;
    fbc_pkg::fbc_step_t r;
    u1 = bm ? `FBC_UNLK1_BYTE : `FBC_UNLK1_WORD;
    u2 = bm ? `FBC_UNLK2_BYTE : `FBC_UNLK2_WORD;
    ofs = (op == fbc_pkg::OP_ID_MFR) ? `FBC_OFS_MFR :
          (op == fbc_pkg::OP_ID_DEV) ? (bm ? `FBC_OFS_DEV_BYTE : `FBC_OFS_DEV_WORD) :
          (bm ? `FBC_OFS_PROT_BYTE : `FBC_OFS_PROT_WORD);
    r = '0;
    // Upper data byte is left zero in command cycles, see RQ7
    case (op)
      fbc_pkg::OP_READ: begin // see RQ9
        r.addr = a; r.rd = 1'b1; r.last = 1'b1;
      end
      fbc_pkg::OP_RESET: begin // see RQ1
        r.addr = a; r.data = {8'h00, `FBC_D_RESET}; r.last = 1'b1;
      end
      fbc_pkg::OP_BYP_PROGRAM: begin // see RQ12
        r.addr = a;
        r.data = (s == 3'h0) ? {8'h00, `FBC_D_PROGRAM} : d;
        r.last = (s == 3'h1);
      end
      fbc_pkg::OP_BYP_EXIT: begin // see RQ13
        r.addr = a;
        r.data = {8'h00, (s == 3'h0) ? `FBC_D_AUTOSEL : `FBC_D_BYP_EXIT};
        r.last = (s == 3'h1);
      end
      fbc_pkg::OP_SECT_ADD: begin // see RQ21
        r.addr = a; r.data = {8'h00, `FBC_D_SECT_ERASE}; r.last = 1'b1;
      end
      fbc_pkg::OP_SUSPEND: begin // see RQ16
        r.addr = a; r.data = {8'h00, `FBC_D_SUSPEND}; r.last = 1'b1;
      end
      fbc_pkg::OP_RESUME: begin // see RQ18
        r.addr = a; r.data = {8'h00, `FBC_D_RESUME}; r.last = 1'b1;
      end
      default: begin
        // Unlock-led sequences, see RQ2 RQ6
        case ((s > 3'h2 && op < fbc_pkg::OP_CHIP_ERASE) ? 3'h7 : s)
          3'h0, 3'h3: begin r.addr = mrg(a, u1); r.data = {8'h00, `FBC_D_UNLK1}; end
          3'h1, 3'h4: begin r.addr = mrg(a, u2); r.data = {8'h00, `FBC_D_UNLK2}; end
          3'h2: begin
            r.addr = mrg(a, u1);
            case (op)
              fbc_pkg::OP_PROGRAM: r.data = {8'h00, `FBC_D_PROGRAM};
              fbc_pkg::OP_BYP_ENTER: begin r.data = {8'h00, `FBC_D_BYPASS}; r.last = 1'b1; end
              fbc_pkg::OP_CHIP_ERASE, fbc_pkg::OP_SECT_ERASE: r.data = {8'h00, `FBC_D_ERASE_SETUP};
              default: r.data = {8'h00, `FBC_D_AUTOSEL}; // see RQ10
            endcase
          end
          default: begin
            r.data = d;
            r.addr = a;
            if (op == fbc_pkg::OP_PROGRAM) begin
              r.last = 1'b1;
            end else if (op == fbc_pkg::OP_CHIP_ERASE || op == fbc_pkg::OP_SECT_ERASE) begin
              // Step 5 closes the erase; step 3 and 4 were covered above, see RQ14 RQ15
              r.addr = (op == fbc_pkg::OP_CHIP_ERASE) ? mrg(a, u1) : a;
              r.data = {8'h00, (op == fbc_pkg::OP_CHIP_ERASE) ? `FBC_D_CHIP_ERASE : `FBC_D_SECT_ERASE};
              r.last = 1'b1;
            end else if (s == 3'h3) begin
              // Autoselect read at bank or sector address, see RQ10 RQ11
              r.addr = {a[18:8], ofs}; r.rd = 1'b1;
            end else begin
              // Leave autoselect again so the bank is back to reading, see RQ1
              r.data = {8'h00, `FBC_D_RESET}; r.last = 1'b1;
            end
          end
        endcase
      end
    endcase
    step_fn = r;
  endfunction : step_fn

  // Commands the device would ignore or abort on are refused here, see RQ20 RQ22 RQ23 RQ17
  function automatic logic op_ok(input fbc_pkg::fbc_op_t op, input logic byp, input logic susp,
                                 input logic ers, input logic chip, input logic win);
    if (chip) op_ok = (op == fbc_pkg::OP_READ);
    else if (ers) op_ok = (op == fbc_pkg::OP_READ) || (op == fbc_pkg::OP_SUSPEND) ||
                          (win && (op == fbc_pkg::OP_SECT_ADD || op == fbc_pkg::OP_RESET));
    else if (byp) op_ok = (op == fbc_pkg::OP_READ) || (op == fbc_pkg::OP_BYP_PROGRAM) ||
                          (op == fbc_pkg::OP_BYP_EXIT);
    else begin
      case (op)
        fbc_pkg::OP_BYP_PROGRAM, fbc_pkg::OP_BYP_EXIT, fbc_pkg::OP_SUSPEND, fbc_pkg::OP_SECT_ADD: op_ok = 1'b0;
        fbc_pkg::OP_RESUME: op_ok = susp;
        fbc_pkg::OP_CHIP_ERASE, fbc_pkg::OP_SECT_ERASE, fbc_pkg::OP_BYP_ENTER: op_ok = !susp;
        default: op_ok = 1'b1;
      endcase
    end
  endfunction : op_ok

  // ==============================
  // Sequencer
  assign stp = step_fn(op_q, step_q, bm_q, addr_q, data_q);
  assign cyc.req = (st_q == fbc_pkg::S_ISSUE);
  assign cyc.wr = !stp.rd;
  assign cyc.addr = stp.addr;
  assign cyc.wdata = stp.data;

  always_comb begin
    st_d = st_q;
    op_d = op_q;
    addr_d = addr_q;
    data_d = data_q;
    bm_d = bm_q;
    step_d = step_q;
    rdat_d = rdat_q;
    rv_d = 1'b0;
    rr_d = rr_q;
    byp_d = byp_q;
    susp_d = susp_q;
    erase_d = erase_q;
    chip_d = chip_q;
    seen_d = seen_q;
    win_d = (win_q != '0) ? win_q - WW'(1) : win_q;
    busy_d = (rb_s2_q == rb_s3_q) ? !rb_s3_q : busy_q;
    // Erase ends when the ready line has gone busy and come back, see RQ19
    if ((erase_q || chip_q) && busy_q) seen_d = 1'b1;
    if ((erase_q || chip_q) && seen_q && !busy_q) begin
      erase_d = 1'b0;
      chip_d = 1'b0;
      seen_d = 1'b0;
    end
    case (st_q)
      fbc_pkg::S_IDLE: if (cmd_valid_in) begin
        op_d = cmd_op_in;
        addr_d = cmd_addr_in;
        data_d = cmd_data_in;
        bm_d = byte_mode_in;
        step_d = 3'h0;
        if (op_ok(cmd_op_in, byp_q, susp_q, erase_q, chip_q, win_q != '0)) begin
          st_d = fbc_pkg::S_ISSUE;
        end else begin
          rv_d = 1'b1;
          rr_d = 1'b1;
        end
      end
      fbc_pkg::S_ISSUE: st_d = fbc_pkg::S_WAIT;
      fbc_pkg::S_WAIT: if (cyc.done) begin
        if (stp.rd) rdat_d = cyc.rdata;
        if (!stp.last) begin
          step_d = step_q + 3'h1;
          st_d = fbc_pkg::S_ISSUE;
        end else begin
          st_d = fbc_pkg::S_IDLE;
          rv_d = 1'b1;
          rr_d = 1'b0;
          case (op_q)
            fbc_pkg::OP_BYP_ENTER: byp_d = 1'b1; // see RQ12
            fbc_pkg::OP_BYP_EXIT: byp_d = 1'b0; // see RQ13
            fbc_pkg::OP_CHIP_ERASE: begin chip_d = 1'b1; seen_d = 1'b0; end
            fbc_pkg::OP_SECT_ERASE, fbc_pkg::OP_SECT_ADD: begin // see RQ21
              erase_d = 1'b1;
              win_d = WW'(ERASE_WINDOW_CYC);
            end
            fbc_pkg::OP_SUSPEND: begin // see RQ16
              susp_d = 1'b1; erase_d = 1'b0; seen_d = 1'b0; win_d = '0;
            end
            fbc_pkg::OP_RESUME: begin // see RQ18
              susp_d = 1'b0; erase_d = 1'b1; seen_d = 1'b0;
            end
            fbc_pkg::OP_RESET: if (erase_q) begin // see RQ21
              erase_d = 1'b0; win_d = '0;
            end
            default: ;
          endcase
        end
      end
      default: st_d = fbc_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= fbc_pkg::S_IDLE;
      op_q <= fbc_pkg::OP_READ;
      addr_q <= 19'h00000;
      data_q <= 16'h0000;
      bm_q <= 1'b0;
      step_q <= 3'h0;
      rdat_q <= 16'h0000;
      rv_q <= 1'b0;
      rr_q <= 1'b0;
      byp_q <= 1'b0;
      susp_q <= 1'b0;
      erase_q <= 1'b0;
      chip_q <= 1'b0;
      seen_q <= 1'b0;
      win_q <= '0;
      busy_q <= 1'b0;
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
      rb_s3_q <= 1'b1;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      addr_q <= addr_d;
      data_q <= data_d;
      bm_q <= bm_d;
      step_q <= step_d;
      rdat_q <= rdat_d;
      rv_q <= rv_d;
      rr_q <= rr_d;
      byp_q <= byp_d;
      susp_q <= susp_d;
      erase_q <= erase_d;
      chip_q <= chip_d;
      seen_q <= seen_d;
      win_q <= win_d;
      busy_q <= busy_d;
      rb_s1_q <= flash_ready_busy_n_in;
      rb_s2_q <= rb_s1_q;
      rb_s3_q <= rb_s2_q;
    end
  end

  fbc_bus_cycle u_cycle (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .cyc(cyc.phy),
    .flash_addr_out(flash_addr_out),
    .flash_ce_n_out(flash_ce_n_out),
    .flash_we_n_out(flash_we_n_out),
    .flash_oe_n_out(flash_oe_n_out),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe_n_out(flash_dq_oe_n_out),
    .flash_dq_in(flash_dq_in)
  );

  assign cmd_ready_out = (st_q == fbc_pkg::S_IDLE);
  assign rsp_valid_out = rv_q;
  assign rsp_refused_out = rr_q;
  assign rsp_data_out = rdat_q;
  assign bypass_out = byp_q;
  assign suspended_out = susp_q;
  assign erasing_out = erase_q || chip_q;
  assign erase_window_out = (win_q != '0);
  assign busy_out = busy_q;

  // ==============================
  // Checks
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  unlock_pair_a: assert property (cyc.req && step_q == 3'h0 && op_q == fbc_pkg::OP_PROGRAM |-> // see RQ2
    cyc.wdata[7:0] == 8'hAA ##[1:40] cyc.req && cyc.wdata[7:0] == 8'h55 && step_q == 3'h1)
    else $error("program did not open with AA then 55");
  byp_prog_mode_a: assert property (cyc.req && op_q == fbc_pkg::OP_BYP_PROGRAM |-> byp_q) // see RQ12
    else $error("bypass program outside bypass mode");
  byp_exit_a: assert property ($fell(byp_q) |-> $past(op_q) == fbc_pkg::OP_BYP_EXIT) // see RQ13
    else $error("bypass left without exit sequence");
  chip_sixth_a: assert property (cyc.req && op_q == fbc_pkg::OP_CHIP_ERASE && step_q == 3'h5 |-> // see RQ14
    cyc.wdata[7:0] == 8'h10 && stp.last)
    else $error("chip erase sixth write wrong");
  sect_sixth_a: assert property (cyc.req && op_q == fbc_pkg::OP_SECT_ERASE && step_q == 3'h5 |-> // see RQ15
    cyc.wdata[7:0] == 8'h30 && cyc.addr == addr_q && stp.last)
    else $error("sector erase sixth write wrong");
  suspend_gate_a: assert property ($rose(susp_q) |-> $past(erase_q)) // see RQ16
    else $error("suspend issued without sector erase");
  resume_gate_a: assert property (st_q == fbc_pkg::S_IDLE && cmd_valid_in && // see RQ18
    cmd_op_in == fbc_pkg::OP_RESUME && !susp_q |=> rsp_valid_out && rsp_refused_out)
    else $error("resume not refused outside suspend");
  autosel_read_a: assert property (cyc.req && op_q == fbc_pkg::OP_ID_MFR && step_q == 3'h3 |-> // see RQ10
    !cyc.wr && $past(cyc.wdata[7:0], 4) == 8'h90)
    else $error("autoselect fourth cycle not a read");
  chip_quiet_a: assert property (chip_q && cyc.req |-> op_q == fbc_pkg::OP_READ) // see RQ22
    else $error("command written during chip erase");
  window_len_a: assert property ($rose(win_q != '0) |-> win_q == WW'(ERASE_WINDOW_CYC)) // see RQ21
    else $error("erase window not started at full length");
endmodule : fbc_host

// ===== tb/fbc_flash_model.sv
// Behavioural two-bank flash device driven through its pins
module fbc_flash_model #(
  parameter logic [15:0] MFR_CODE = 16'h00C3, // Arbitrary identity value
  parameter int BUSY_NS = 600
) (
  // Pins
  input wire logic [18:0] addr_in,
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic [15:0] dq_in,
  input wire logic byte_mode_in,
  output logic [15:0] dq_out,
  output logic rb_n_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [34:0] wlog[$];
  logic [18:0] lat_a;
  logic [15:0] last_d = 16'h0000;
  logic asel = 1'b0;
  wire strobe_n = ce_n_in | we_n_in;
  initial rb_n_out = 1'b1;
  always @(negedge strobe_n) lat_a = addr_in;
  always @(posedge strobe_n) begin
    wlog.push_back({lat_a, dq_in});
    if (dq_in[7:0] == 8'h90) asel = 1'b1;
    if (dq_in[7:0] inside {8'hF0, 8'h00}) asel = 1'b0;
    if (dq_in[7:0] == 8'hB0) rb_n_out <= #20 1'b1;
    if (dq_in[7:0] inside {8'h10, 8'h30}) begin
      rb_n_out <= #20 1'b0;
      rb_n_out <= #(BUSY_NS) 1'b1;
    end
  end
  // Released bus shows the inverse of the last word so stale data never matches
  always @* begin
    if (!ce_n_in && !oe_n_in) begin
      if (!asel) dq_out = ~addr_in[15:0];
      else if (addr_in[7:0] == 8'h00) dq_out = MFR_CODE;
      else if (addr_in[7:0] == (byte_mode_in ? 8'h04 : 8'h02)) dq_out = {15'h0, addr_in[18:12] == 7'h05};
      else dq_out = 16'h5A3C;
      last_d = dq_out;
    end else dq_out = ~last_d;
  end
endmodule : fbc_flash_model

// ===== tb/test_fbc_host.sv
// Self-checking bench for the flash command sequencer
module test_fbc_host;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_in, resetn_in, cmd_valid_in, byte_mode_in, ce_n, we_n, oe_n, dq_oe_n, rb_n;
  logic cmd_ready_out, rsp_valid_out, rsp_refused_out, bypass_out, suspended_out, erasing_out, win, busy;
  fbc_pkg::fbc_op_t cmd_op_in;
  logic [18:0] cmd_addr_in, faddr;
  logic [15:0] cmd_data_in, rsp_data_out, host_dq, dev_dq, dq_pin;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  assign dq_pin = dq_oe_n ? dev_dq : host_dq;
  fbc_host #(.ERASE_WINDOW_CYC(40)) DUT (.clock_in(clock_in), .resetn_in(resetn_in), .cmd_valid_in(cmd_valid_in),
    .cmd_ready_out(cmd_ready_out), .cmd_op_in(cmd_op_in), .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in),
    .byte_mode_in(byte_mode_in), .rsp_valid_out(rsp_valid_out), .rsp_refused_out(rsp_refused_out),
    .rsp_data_out(rsp_data_out), .bypass_out(bypass_out), .suspended_out(suspended_out), .erasing_out(erasing_out),
    .erase_window_out(win), .busy_out(busy), .flash_addr_out(faddr), .flash_ce_n_out(ce_n), .flash_we_n_out(we_n),
    .flash_oe_n_out(oe_n), .flash_dq_out(host_dq), .flash_dq_oe_n_out(dq_oe_n), .flash_dq_in(dq_pin),
    .flash_ready_busy_n_in(rb_n));
  fbc_flash_model dev (.addr_in(faddr), .ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n), .dq_in(dq_pin),
    .byte_mode_in(byte_mode_in), .dq_out(dev_dq), .rb_n_out(rb_n));
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  // Whole run is under two thousand cycles
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      stop_test();
    end
  end
  // ==============================
  // Shared tasks
  task stop_test();
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task check(input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task cmd(input fbc_pkg::fbc_op_t op, input logic [18:0] a, input logic [15:0] d, input logic r, input int nw);
    int n;
    n = 0;
    dev.wlog.delete();
    @(posedge clock_in);
    cmd_op_in <= op;
    cmd_addr_in <= a;
    cmd_data_in <= d;
    cmd_valid_in <= 1'b1;
    @(posedge clock_in);
    cmd_valid_in <= 1'b0;
    while (n < 3000 && rsp_valid_out !== 1'b1) begin
      @(negedge clock_in);
      n++;
    end
    check(rsp_refused_out, r);
    check(dev.wlog.size(), nw);
  endtask : cmd
  task w(input int i, input logic [18:0] a, input logic [15:0] d);
    check(dev.wlog[i], {a, d});
  endtask : w
  task unl(input logic [18:0] a, input logic [15:0] d, input int i);
    w(i, {a[18:12], byte_mode_in ? 12'hAAA : 12'h555}, 16'h00AA);
    w(i + 1, {a[18:12], byte_mode_in ? 12'h555 : 12'h2AA}, 16'h0055);
    w(i + 2, {a[18:12], byte_mode_in ? 12'hAAA : 12'h555}, d);
  endtask : unl
  task settle();
    for (int n = 0; n < 3000 && erasing_out !== 1'b0; n++) @(negedge clock_in);
    check(erasing_out, 1'b0);
  endtask : settle
  // ==============================
  // Scenarios
  task t_read_prog();
    cmd(fbc_pkg::OP_READ, 19'h41234, 16'h0, 1'b0, 0);
    check(rsp_data_out, 16'hEDCB);
    for (int b = 0; b < 2; b++) begin
      byte_mode_in <= b[0];
      cmd(fbc_pkg::OP_PROGRAM, 19'h3ABCD, 16'hBEEF, 1'b0, 4);
      unl(19'h3ABCD, 16'h00A0, 0);
      w(3, 19'h3ABCD, 16'hBEEF);
    end
    byte_mode_in <= 1'b0;
  endtask : t_read_prog
  task t_ident();
    cmd(fbc_pkg::OP_ID_MFR, 19'h50000, 16'h0, 1'b0, 4);
    unl(19'h50000, 16'h0090, 0);
    w(3, 19'h50000, 16'h00F0);
    check(rsp_data_out, 16'h00C3);
    cmd(fbc_pkg::OP_ID_DEV, 19'h50000, 16'h0, 1'b0, 4);
    check(rsp_data_out, 16'h5A3C);
    cmd(fbc_pkg::OP_PROT_QUERY, 19'h05000, 16'h0, 1'b0, 4);
    check(rsp_data_out, 16'h0001);
    cmd(fbc_pkg::OP_PROT_QUERY, 19'h06000, 16'h0, 1'b0, 4);
    check(rsp_data_out, 16'h0000);
  endtask : t_ident
  task t_bypass();
    cmd(fbc_pkg::OP_SUSPEND, 19'h0, 16'h0, 1'b1, 0);
    cmd(fbc_pkg::OP_RESUME, 19'h0, 16'h0, 1'b1, 0);
    cmd(fbc_pkg::OP_BYP_ENTER, 19'h10000, 16'h0, 1'b0, 3);
    unl(19'h10000, 16'h0020, 0);
    check(bypass_out, 1'b1);
    cmd(fbc_pkg::OP_PROGRAM, 19'h10010, 16'h1111, 1'b1, 0);
    cmd(fbc_pkg::OP_BYP_PROGRAM, 19'h10010, 16'h1234, 1'b0, 2);
    w(0, 19'h10010, 16'h00A0);
    w(1, 19'h10010, 16'h1234);
    cmd(fbc_pkg::OP_BYP_EXIT, 19'h10000, 16'h0, 1'b0, 2);
    w(0, 19'h10000, 16'h0090);
    w(1, 19'h10000, 16'h0000);
    check(bypass_out, 1'b0);
    cmd(fbc_pkg::OP_RESET, 19'h20000, 16'h0, 1'b0, 1);
    w(0, 19'h20000, 16'h00F0);
  endtask : t_bypass
  task t_erase();
    cmd(fbc_pkg::OP_CHIP_ERASE, 19'h20000, 16'h0, 1'b0, 6);
    unl(19'h20000, 16'h0080, 0);
    unl(19'h20000, 16'h0010, 3);
    for (int n = 0; n < 400 && busy !== 1'b1; n++) @(negedge clock_in);
    check(busy, 1'b1);
    cmd(fbc_pkg::OP_PROGRAM, 19'h20010, 16'h1, 1'b1, 0);
    settle();
    cmd(fbc_pkg::OP_SECT_ERASE, 19'h13000, 16'h0, 1'b0, 6);
    unl(19'h13000, 16'h0080, 0);
    w(5, 19'h13000, 16'h0030);
    check(win, 1'b1);
    cmd(fbc_pkg::OP_SECT_ADD, 19'h14000, 16'h0, 1'b0, 1);
    w(0, 19'h14000, 16'h0030);
    cmd(fbc_pkg::OP_SUSPEND, 19'h10000, 16'h0, 1'b0, 1);
    w(0, 19'h10000, 16'h00B0);
    check(suspended_out, 1'b1);
    cmd(fbc_pkg::OP_RESUME, 19'h10000, 16'h0, 1'b0, 1);
    w(0, 19'h10000, 16'h0030);
    check(suspended_out, 1'b0);
    settle();
  endtask : t_erase
  initial begin
    resetn_in = 1'b0;
    cmd_valid_in = 1'b0;
    cmd_op_in = fbc_pkg::OP_READ;
    cmd_addr_in = 19'h0;
    cmd_data_in = 16'h0;
    byte_mode_in = 1'b0;
    repeat (10) @(posedge clock_in);
    check({cmd_ready_out, ce_n, we_n, oe_n, dq_oe_n, rsp_valid_out, bypass_out}, 7'h7C);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    t_read_prog();
    t_ident();
    t_bypass();
    t_erase();
    stop_test();
  end
endmodule : test_fbc_host
